// >>> core/lpm_defines.vh
// lpm_defines.vh: constants for the low-power mode controller.
// assumes a 40 MHz system clock; frequencies are given in kHz.
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH

`define LPM_CLK_KHZ 40000
`define LPM_RANGE1_MAX_KHZ 16'h7D00
`define LPM_RANGE2_MAX_KHZ 16'h3E80
`define LPM_RANGE3_MAX_KHZ 16'h0FA0
`define LPM_LP_RUN_KHZ 16'h0041
// wake latencies in ns, cycles derived (longest time, rounded down)
`define LPM_STOP_WAKE_NS 8000
`define LPM_STBY_WAKE_NS 60000
`define LPM_STOP_WAKE_CYC ((`LPM_STOP_WAKE_NS * (`LPM_CLK_KHZ / 1000)) / 1000)
`define LPM_STBY_WAKE_CYC ((`LPM_STBY_WAKE_NS * (`LPM_CLK_KHZ / 1000)) / 1000)
// voltage range codes
`define LPM_RANGE1 2'h1
`define LPM_RANGE2 2'h2
`define LPM_RANGE3 2'h3
// requested low-power mode codes
`define LPM_REQ_SLEEP 2'h0
`define LPM_REQ_STOP 2'h1
`define LPM_REQ_STBY 2'h2
// clock source codes
`define LPM_SRC_MSI_OSC 2'h0
`define LPM_SRC_FAST_RC 2'h1
`define LPM_SRC_FAST_XTAL 2'h2
`define LPM_SRC_PLL 2'h3
// external event line count
`define LPM_EVT_LINES 16

`endif

// >>> core/lpm_wake_timer.v
// lpm_wake_timer.v: counts down a wake latency and pulses when done.
// assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
`include "lpm_defines.vh"

module lpm_wake_timer #(
    parameter CYCLES = 320,
    parameter W = 12
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_start,
    output reg o_done
);
    reg [W-1:0] count;
    reg busy;

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            count <= {W{1'b0}};
            busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                count <= CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1};
                busy <= 1'b1;
            end else if (busy) begin
                if (count == {W{1'b0}}) begin
                    busy <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    count <= count - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// >>> core/lpm_ctrl.v
// lpm_ctrl.v: power-mode sequencer, clock-range limiter, wake qualifier.
// assumes all inputs synchronous to i_clk_sys; cpu holds wfi until woken.
`timescale 1ns/1ps
`include "lpm_defines.vh"

module lpm_ctrl #(
    parameter STBY_WAKE_CYC = `LPM_STBY_WAKE_CYC,
    parameter STOP_WAKE_CYC = `LPM_STOP_WAKE_CYC
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire [1:0] i_range,
    input wire [15:0] i_req_cpu_khz,
    input wire [1:0] i_req_clk_src,
    input wire i_lp_run_req,
    input wire i_lp_sleep_sel,
    input wire [1:0] i_mode_sel,
    input wire i_rtc_keep,
    input wire i_wfi,
    input wire i_cpu_halted,
    input wire i_periph_event,
    input wire [15:0] i_external_event_lines,
    input wire i_programmable_voltage_detector,
    input wire i_comp_event,
    input wire i_int_ref_on,
    input wire i_rtc_event,
    input wire i_usb_wakeup,
    input wire i_external_reset_pin_n,
    input wire i_independent_watchdog_rst,
    input wire [2:0] i_wakeup_pin,
    output reg [15:0] o_cpu_khz,
    output reg [1:0] o_clk_src,
    output reg o_clk_err,
    output reg o_cpu_clk_en,
    output reg o_regulator_lp,
    output reg o_core_pwr_on,
    output reg o_core_clk_en,
    output reg o_multispeed_internal_osc_en,
    output reg o_fast_internal_rc_osc_en,
    output reg o_fast_external_crystal_osc_en,
    output reg o_pll_en,
    output reg o_slow_osc_en,
    output reg o_ram_retain,
    output reg o_core_rst,
    output reg o_wake
);
    localparam S_RUN = 7'h01;
    localparam S_WAIT = 7'h02;
    localparam S_SLEEP = 7'h04;
    localparam S_STOP = 7'h08;
    localparam S_STBY = 7'h10;
    localparam S_WSTOP = 7'h20;
    localparam S_WSTBY = 7'h40;

    reg [6:0] state;
    reg [6:0] next_state;
    wire awake;
    reg [1:0] mode;
    reg rtc_kept;
    reg lp_reg_sleep;
    reg [2:0] pin_prev;
    wire [2:0] pin_rise;
    wire stop_wake;
    wire stby_wake;
    wire stop_done;
    wire stby_done;
    reg [15:0] lim;
    reg src_ok;

    assign pin_rise = i_wakeup_pin & ~pin_prev;
    // cpu or peripherals still clocked, fast oscillators may run
    assign awake = next_state == S_RUN || next_state == S_WAIT ||
        next_state == S_SLEEP;
    // comparators only count with the internal reference on
    assign stop_wake = (|i_external_event_lines) | i_usb_wakeup
        | i_programmable_voltage_detector | (i_comp_event & i_int_ref_on)
        | (rtc_kept & i_rtc_event);
    assign stby_wake = ~i_external_reset_pin_n | (|pin_rise)
        | (rtc_kept & (i_independent_watchdog_rst | i_rtc_event));

    // one cycle of the latency goes to the return edge into run
    lpm_wake_timer #(.CYCLES(STOP_WAKE_CYC - 1), .W(12)) u_stop_tmr (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_start(state == S_STOP && stop_wake),
        .o_done(stop_done)
    );

    lpm_wake_timer #(.CYCLES(STBY_WAKE_CYC - 1), .W(12)) u_stby_tmr (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_start(state == S_STBY && stby_wake),
        .o_done(stby_done)
    );

    ////////////////////////////////////////////////////////////////////
    // clock range limiting
    always @* begin
        case (i_range)
            `LPM_RANGE1: lim = `LPM_RANGE1_MAX_KHZ;
            `LPM_RANGE2: lim = `LPM_RANGE2_MAX_KHZ;
            default: lim = `LPM_RANGE3_MAX_KHZ;
        endcase
        src_ok = (i_range == `LPM_RANGE1) || (i_range == `LPM_RANGE2) ||
            (i_req_clk_src == `LPM_SRC_MSI_OSC);
    end

    ////////////////////////////////////////////////////////////////////
    // mode sequencing
    always @* begin
        next_state = state;
        case (state)
            S_RUN: begin
                if (i_wfi)
                    next_state = S_WAIT;
            end
            S_WAIT: begin
                if (!i_wfi)
                    next_state = S_RUN;
                else if (i_cpu_halted) begin
                    case (mode)
                        `LPM_REQ_STOP: next_state = S_STOP;
                        `LPM_REQ_STBY: next_state = S_STBY;
                        default: next_state = S_SLEEP;
                    endcase
                end
            end
            S_SLEEP: begin
                if (i_periph_event | stop_wake)
                    next_state = S_RUN;
            end
            S_STOP: begin
                if (stop_wake)
                    next_state = S_WSTOP;
            end
            S_WSTOP: begin
                if (stop_done)
                    next_state = S_RUN;
            end
            S_STBY: begin
                if (stby_wake)
                    next_state = S_WSTBY;
            end
            S_WSTBY: begin
                if (stby_done)
                    next_state = S_RUN;
            end
            default: next_state = S_RUN;
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            state <= S_RUN;
            mode <= `LPM_REQ_SLEEP;
            rtc_kept <= 1'b0;
            lp_reg_sleep <= 1'b0;
            pin_prev <= 3'h0;
            o_wake <= 1'b0;
            o_cpu_khz <= 16'h0000;
            o_clk_src <= `LPM_SRC_MSI_OSC;
            o_clk_err <= 1'b0;
        end else begin
            state <= next_state;
            pin_prev <= i_wakeup_pin;
            o_wake <= (state != S_RUN && state != S_WAIT) &&
                next_state == S_RUN;
            if (state == S_RUN && i_wfi) begin
                mode <= i_mode_sel;
                rtc_kept <= i_rtc_keep;
                lp_reg_sleep <= i_lp_sleep_sel;
            end
            if (i_lp_run_req) begin
                o_cpu_khz <= `LPM_LP_RUN_KHZ;
                o_clk_src <= `LPM_SRC_MSI_OSC;
                o_clk_err <= 1'b0;
            end else if (!src_ok) begin
                o_cpu_khz <= (o_cpu_khz > lim) ? lim : o_cpu_khz;
                o_clk_src <= `LPM_SRC_MSI_OSC;
                o_clk_err <= 1'b1;
            end else begin
                o_cpu_khz <= (i_req_cpu_khz > lim) ? lim : i_req_cpu_khz;
                o_clk_src <= i_req_clk_src;
                o_clk_err <= i_req_cpu_khz > lim;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power, clock and retention outputs per state
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_cpu_clk_en <= 1'b1;
            o_regulator_lp <= 1'b0;
            o_core_pwr_on <= 1'b1;
            o_core_clk_en <= 1'b1;
            o_multispeed_internal_osc_en <= 1'b1;
            o_fast_internal_rc_osc_en <= 1'b0;
            o_fast_external_crystal_osc_en <= 1'b0;
            o_pll_en <= 1'b0;
            o_slow_osc_en <= 1'b1;
            o_ram_retain <= 1'b1;
            o_core_rst <= 1'b0;
        end else begin
            o_cpu_clk_en <= next_state == S_RUN || next_state == S_WAIT;
            o_core_clk_en <= !(next_state == S_STOP ||
                next_state == S_STBY || next_state == S_WSTOP ||
                next_state == S_WSTBY);
            o_regulator_lp <= (next_state == S_SLEEP && lp_reg_sleep) ||
                next_state == S_STOP || next_state == S_WSTOP ||
                ((next_state == S_RUN || next_state == S_WAIT) &&
                i_lp_run_req);
            o_multispeed_internal_osc_en <= awake && (i_lp_run_req ||
                o_clk_src == `LPM_SRC_MSI_OSC);
            o_fast_internal_rc_osc_en <= awake && !i_lp_run_req &&
                o_clk_src == `LPM_SRC_FAST_RC;
            o_fast_external_crystal_osc_en <= awake && !i_lp_run_req &&
                o_clk_src == `LPM_SRC_FAST_XTAL;
            o_pll_en <= awake && !i_lp_run_req &&
                o_clk_src == `LPM_SRC_PLL;
            // slow osc kept unless deep mode without rtc
            o_slow_osc_en <= awake || rtc_kept;
            o_core_pwr_on <= !(next_state == S_STBY ||
                next_state == S_WSTBY);
            o_ram_retain <= !(next_state == S_STBY ||
                next_state == S_WSTBY);
            o_core_rst <= state == S_WSTBY;
        end
    end

endmodule

// >>> verif/lpm_cpu_model.sv
// lpm_cpu_model.sv: cpu stand-in that halts after a wfi request.
// assumes tb pulses i_sleep_go; controller o_wake releases it.
`timescale 1ns/1ps
module lpm_cpu_model (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_sleep_go,
    input wire i_wake,
    output logic o_wfi,
    output logic o_halted
);
always @(posedge i_clk_sys) begin
    if (i_rst || i_wake) begin
        o_wfi <= 1'h0;
        o_halted <= 1'h0;
    end else begin
        if (i_sleep_go)
            o_wfi <= 1'h1;
        o_halted <= o_wfi;
    end
end
endmodule

// >>> verif/lpm_ctrl_properties.sv
// lpm_ctrl_properties.sv: port checker for the power-mode controller.
// assumes bind onto lpm_ctrl; one clock, sync high reset.
`timescale 1ns/1ps
module lpm_ctrl_chk #(
    parameter int STBY_WAKE_CYC = 8,
    parameter int STOP_WAKE_CYC = 4
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire [1:0] i_range,
    input wire i_cpu_halted,
    input wire [15:0] i_external_event_lines,
    input wire [2:0] i_wakeup_pin,
    input wire [15:0] o_cpu_khz,
    input wire [1:0] o_clk_src,
    input wire o_cpu_clk_en,
    input wire o_core_clk_en,
    input wire o_core_pwr_on,
    input wire o_regulator_lp,
    input wire o_ram_retain,
    input wire o_multispeed_internal_osc_en,
    input wire o_pll_en,
    input wire o_core_rst,
    input wire o_wake
);
default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (i_rst);
localparam int STOP_MAX = STOP_WAKE_CYC + 4;
localparam int STBY_MAX = STBY_WAKE_CYC + 4;
sequence s_stop_evt;
    !o_core_clk_en && o_core_pwr_on && (|i_external_event_lines);
endsequence
sequence s_stby_pin;
    !o_core_pwr_on && (|(i_wakeup_pin & ~$past(i_wakeup_pin)));
endsequence
range1_cap_a: assert property (o_cpu_khz <= 16'h7D00)
    else $error("cpu clock over range one cap");
range2_cap_a: assert property ($past(i_range) == 2'h2 &&
    o_cpu_clk_en && $past(o_cpu_clk_en) |-> o_cpu_khz <= 16'h3E80)
    else $error("cpu clock over range two cap");
range3_src_a: assert property ($past(i_range) == 2'h3 &&
    o_cpu_clk_en && $past(o_cpu_clk_en) |->
    o_clk_src == 2'h0 && o_cpu_khz <= 16'h0FA0)
    else $error("range three clock wrong");
halt_first_a: assert property ($fell(o_cpu_clk_en) |->
    $past(i_cpu_halted) || $past(i_cpu_halted, 2))
    else $error("mode entered before cpu halt");
stop_clocks_a: assert property (
    !o_core_clk_en && o_core_pwr_on && !o_wake |-> !o_pll_en &&
    !o_multispeed_internal_osc_en && o_regulator_lp && o_ram_retain)
    else $error("stop state outputs wrong");
stby_off_a: assert property (!o_core_pwr_on |->
    !o_ram_retain && !o_core_clk_en && !o_cpu_clk_en)
    else $error("standby state outputs wrong");
stop_wake_a: assert property (s_stop_evt |-> ##[1:STOP_MAX] o_wake)
    else $error("stop wake too late");
stby_wake_a: assert property (s_stby_pin |-> ##[1:STBY_MAX] o_wake)
    else $error("standby wake too late");
stby_reboot_a: assert property ($rose(o_core_pwr_on) |->
    o_core_rst)
    else $error("core not held in reset on standby exit");
endmodule
bind lpm_ctrl lpm_ctrl_chk #(.STBY_WAKE_CYC(STBY_WAKE_CYC),
    .STOP_WAKE_CYC(STOP_WAKE_CYC)) u_lpm_ctrl_chk (.*);

// >>> verif/tb_top.sv
// tb_top.sv: self-checking bench for the power-mode controller.
// assumes lpm_ctrl, its bound checker and the cpu stand-in.
`timescale 1ns/1ps
module tb_top;
logic i_clk_sys = 1'h0;
logic i_rst = 1'h1;
logic go = 1'h0;
logic [1:0] i_range = 2'h1, i_req_clk_src = 2'h0, i_mode_sel = 2'h0;
logic [15:0] i_req_cpu_khz = 16'h0FA0, i_external_event_lines = 16'h0;
logic [2:0] i_wakeup_pin = 3'h0;
logic i_lp_run_req = 1'h0, i_lp_sleep_sel = 1'h0, i_rtc_keep = 1'h0;
logic i_periph_event = 1'h0, i_programmable_voltage_detector = 1'h0;
logic i_comp_event = 1'h0, i_int_ref_on = 1'h1, i_rtc_event = 1'h0;
logic i_usb_wakeup = 1'h0, i_independent_watchdog_rst = 1'h0;
logic i_external_reset_pin_n = 1'h1;
wire i_wfi, i_cpu_halted, o_clk_err, o_cpu_clk_en, o_regulator_lp;
wire o_core_pwr_on, o_core_clk_en, o_multispeed_internal_osc_en;
wire o_fast_internal_rc_osc_en, o_fast_external_crystal_osc_en;
wire o_pll_en, o_slow_osc_en, o_ram_retain, o_core_rst, o_wake;
wire [15:0] o_cpu_khz;
wire [1:0] o_clk_src;
int miscompares = 0;
int compares = 0;
// range, source, request, granted khz, granted source
logic [37:0] tbl [5] = '{{2'h1, 2'h3, 16'h7D00, 16'h7D00, 2'h3},
    {2'h1, 2'h3, 16'h9C40, 16'h7D00, 2'h3},
    {2'h2, 2'h2, 16'h4E20, 16'h3E80, 2'h2},
    {2'h2, 2'h1, 16'h3E80, 16'h3E80, 2'h1},
    {2'h3, 2'h0, 16'h1F40, 16'h0FA0, 2'h0}};
always #12.5 i_clk_sys = ~i_clk_sys;
lpm_ctrl #(.STBY_WAKE_CYC(8), .STOP_WAKE_CYC(4)) u_lpm_ctrl (.*);
lpm_cpu_model u_lpm_cpu_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_sleep_go(go), .i_wake(o_wake), .o_wfi(i_wfi),
    .o_halted(i_cpu_halted));
task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e) begin
        miscompares++;
        $display("mismatch %s exp %h seen %h", n, e, s);
    end
endtask
task automatic stop_test;
    if (miscompares == 0 && compares > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task automatic tick(int n);
    repeat (n) @(posedge i_clk_sys);
endtask
task automatic look(int n);
    tick(n);
    #1;
endtask
// w=1 waits for the wake pulse, w=0 for the cpu clock to stop
task automatic till(bit w);
    int n = 0;
    #1;
    while ((w ? o_wake : !o_cpu_clk_en) !== 1'h1) begin
        look(1);
        if (++n > 40) begin
            miscompares++;
            stop_test;
        end
    end
endtask
task automatic drive(int k);
    {i_wakeup_pin[2], i_independent_watchdog_rst, i_usb_wakeup,
        i_rtc_event, i_comp_event, i_programmable_voltage_detector,
        i_external_event_lines[15], i_periph_event} <= 8'h1 << k;
    i_external_reset_pin_n <= (k != 8);
endtask
task automatic enter(logic [1:0] m, logic r, logic lps);
    tick(1);
    i_mode_sel <= m;
    i_rtc_keep <= r;
    i_lp_sleep_sel <= lps;
    go <= 1'h1;
    tick(1);
    go <= 1'h0;
    till(0);
    look(1);
endtask
// one-cycle wake source; e says whether a wake is due
task automatic pulse(int k, bit e);
    tick(1);
    drive(k);
    tick(1);
    drive(9);
    if (e) begin
        till(1);
        look(1);
    end else begin
        look(14);
        chk("asleep", o_cpu_clk_en, 0);
    end
endtask
initial begin
    tick(5);
    i_rst <= 1'h0;
    #1;
    chk("khz_rst", o_cpu_khz, 0);
    chk("msi_rst", o_multispeed_internal_osc_en, 1);
    foreach (tbl[j]) begin
        tick(1);
        {i_range, i_req_clk_src, i_req_cpu_khz} <= tbl[j][37:18];
        look(2);
        chk("khz", o_cpu_khz, tbl[j][17:2]);
        chk("src", o_clk_src, tbl[j][1:0]);
        chk("rc_en", o_fast_internal_rc_osc_en,
            tbl[j][1:0] == 2'h1);
        chk("xtal_en", o_fast_external_crystal_osc_en,
            tbl[j][1:0] == 2'h2);
        chk("pll_en", o_pll_en, tbl[j][1:0] == 2'h3);
    end
    tick(1);
    i_req_clk_src <= 2'h1;
    look(2);
    chk("src_msi", o_clk_src, 0);
    chk("err", o_clk_err, 1);
    tick(1);
    {i_range, i_req_clk_src, i_lp_run_req} <= {2'h1, 2'h0, 1'h1};
    look(2);
    chk("lp_khz", o_cpu_khz, 16'h0041);
    chk("lp_reg", o_regulator_lp, 1);
    tick(1);
    i_lp_run_req <= 1'h0;
    enter(2'h0, 0, 0);
    chk("sleep_core", o_core_clk_en, 1);
    pulse(0, 1);
    enter(2'h0, 0, 1);
    chk("lps_reg", o_regulator_lp, 1);
    pulse(1, 1);
    chk("run_reg", o_regulator_lp, 0);
    enter(2'h1, 1, 0);
    chk("stop_slow", o_slow_osc_en, 1);
    chk("stop_pll", o_pll_en, 0);
    pulse(4, 1);
    for (int k = 1; k < 6; k++) begin
        enter(2'h1, 0, 0);
        chk("stop_slow0", o_slow_osc_en, 0);
        pulse(k, k != 4);
        if (k == 4)
            pulse(1, 1);
    end
    tick(1);
    i_int_ref_on <= 1'h0;
    enter(2'h1, 0, 0);
    pulse(3, 0);
    pulse(1, 1);
    tick(1);
    i_int_ref_on <= 1'h1;
    for (int r = 0; r < 2; r++) begin
        for (int k = 4; k < 9; k++) begin
            enter(2'h2, r[0], 0);
            chk("stby_pwr", o_core_pwr_on, 0);
            chk("stby_slow", o_slow_osc_en, r[0]);
            pulse(k, k > 6 || (r == 1 && k != 5));
            if (!(k > 6 || (r == 1 && k != 5)))
                pulse(7, 1);
        end
    end
    stop_test;
end
endmodule
